// File: design/fmr_defs.vh
// constants shared by the modbus slave framer files
`ifndef FMR_DEFS_VH
`define FMR_DEFS_VH

// ascii framing characters
`define FMR_CH_START 8'h3A
`define FMR_CH_CR 8'h0D
`define FMR_CH_LF 8'h0A
`define FMR_CH_ZERO 8'h30
`define FMR_CH_NINE 8'h39
`define FMR_CH_UA 8'h41
`define FMR_CH_UF 8'h46
`define FMR_DIGIT_TEN 4'hA

// addressing and function codes
`define FMR_ADDR_BCAST 8'h00
`define FMR_ADDR_TOP 8'hFE
`define FMR_FUNC_READ 8'h03
`define FMR_FUNC_WRITE 8'h06

// checksum constants
`define FMR_CRC_INIT 16'hFFFF
`define FMR_CRC_POLY 16'hA001
`define FMR_CRC_SHIFTS 8

// serial character length per mode, in bits
`define FMR_ASCII_CHAR_BITS 4'hA
`define FMR_RTU_CHAR_BITS 4'hB

// message geometry
`define FMR_REQ_BODY 5'h06
`define FMR_ASCII_CHK_LEN 5'h01
`define FMR_RTU_CHK_LEN 5'h02
`define FMR_MAX_BYTES 5'h14
`define FMR_MAX_WORDS 16'h0007
`define FMR_RD_HDR 5'h03
`define FMR_ASCII_TAIL_LAST 2'h3
`define FMR_RTU_TAIL_LAST 2'h1

// buffer geometry
`define FMR_MEM_AW 5
`define FMR_MEM_DEPTH 32

// rtu silent gap: time in ms and clock in khz
`define FMR_GAP_MS 10
`define FMR_CLK_KHZ 250000
`define FMR_GAP_W 22

`endif

// File: design/fmr_mem.v
// small byte buffer holding the reply message
`timescale 1ns/1ps
`default_nettype none
`include "fmr_defs.vh"

module fmr_mem
(
  input wire core_clk,
  input wire wr_en,
  input wire [`FMR_MEM_AW-1:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [`FMR_MEM_AW-1:0] rd_addr,
  output reg [7:0] rd_data
);

  reg [7:0] store [0:`FMR_MEM_DEPTH-1];

  // write port and registered read port
  always @(posedge core_clk)
  begin
    if (wr_en)
    begin
      store[wr_addr] <= wr_data;
    end
    rd_data <= store[rd_addr];
  end

endmodule // fmr_mem
`default_nettype wire

// File: design/fmr_chk.v
// running lrc sum and crc over a byte stream
`timescale 1ns/1ps
`default_nettype none
`include "fmr_defs.vh"

module fmr_chk
(
  input wire core_clk,
  input wire rst,
  input wire clr,
  input wire en,
  input wire [7:0] din,
  output reg [7:0] sum_r,
  output reg [15:0] crc_r
);

  // one byte through the crc: xor into low half, eight right shifts
  function [15:0] fmr_crc_step;
    input [15:0] crc_in;
    input [7:0] b;
    integer k;
    reg [15:0] c;
    begin
      c = crc_in ^ {8'h00, b};
      for (k = 0; k < `FMR_CRC_SHIFTS; k = k + 1)
      begin
        if (c[0])
          c = (c >> 1) ^ `FMR_CRC_POLY;
        else
          c = c >> 1;
      end
      fmr_crc_step = c;
    end
  endfunction

  wire [7:0] sum_base = clr ? 8'h00 : sum_r;
  wire [15:0] crc_base = clr ? `FMR_CRC_INIT : crc_r;

  // clear and first byte may come together
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sum_r <= 8'h00;
      crc_r <= `FMR_CRC_INIT;
    end
    else if (en)
    begin
      sum_r <= sum_base + din;
      crc_r <= fmr_crc_step(crc_base, din);
    end
    else if (clr)
    begin
      sum_r <= 8'h00;
      crc_r <= `FMR_CRC_INIT;
    end
  end

endmodule // fmr_chk
`default_nettype wire

// File: design/fmr_framer.v
// modbus slave framer: ascii and rtu request parsing, read and single write replies
//
// Function
// [RULE1] answer only frames addressed to our own station address setting
// [RULE2] ascii carries each byte as two hex characters, upper nibble first
// [RULE3] hex digits are 30H..39H and uppercase 41H..46H
// [RULE4] ascii serial characters are 10-bit frames
// [RULE5] rtu serial characters are 11-bit frames with eight data bits
// [RULE6] ascii colon 3AH starts a new message
// [RULE7] ascii message ends with CR then LF after the checksum
// [RULE8] ascii address then function follow the colon, two hex characters each
// [RULE9] ascii data field at most 16 bytes
// [RULE10] ascii 8-bit lrc follows data, high character first
// [RULE11] rtu messages bounded by at least 10ms line silence
// [RULE12] rtu address and function are raw bytes after the gap
// [RULE13] rtu 16-bit crc closes message, low byte first
// [RULE14] address 00H is broadcast, accepted by every drive
// [RULE15] addresses 01H..FEH select the drive with that station number
// [RULE16] function 03H carries start register and word count, high byte first
// [RULE17] read reply: address, function, byte count, values high first, checksum
// [RULE18] function 06H carries register number then value, high byte first
// [RULE19] lrc is negated 8-bit sum of address through last data
// [RULE20] crc starts FFFFH, per byte xor then eight shifts with A001H
// [RULE21] single write reply echoes address, function, register and value
// [RULE22] drop bad checksum or foreign address; never reply to broadcast
`timescale 1ns/1ps
`default_nettype none
`include "fmr_defs.vh"

module fmr_framer
#(
  parameter [`FMR_GAP_W-1:0] GAP_CYCLES = `FMR_GAP_MS * `FMR_CLK_KHZ
)
(
  input wire core_clk,
  input wire rst,
  input wire ascii_mode,
  input wire [7:0] station_address_setting,
  input wire rx_valid,
  input wire [7:0] rx_data,
  output reg tx_valid_r,
  output reg [7:0] tx_data_r,
  input wire tx_ready,
  output reg [3:0] char_bits_r,
  output reg reg_rd_req_r,
  output reg [15:0] reg_rd_addr_r,
  input wire [15:0] reg_rd_data,
  output reg reg_wr_req_r,
  output reg [15:0] reg_wr_addr_r,
  output reg [15:0] reg_wr_data_r,
  output reg frame_drop_r
);

  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_BUILD = 7'h02;
  localparam [6:0] S_START = 7'h04;
  localparam [6:0] S_FETCH = 7'h08;
  localparam [6:0] S_LOAD = 7'h10;
  localparam [6:0] S_EMIT = 7'h20;
  localparam [6:0] S_TAIL = 7'h40;

  // hex character test and value
  function fmr_is_hex;
    input [7:0] c;
    begin
      fmr_is_hex = ((c >= `FMR_CH_ZERO) && (c <= `FMR_CH_NINE)) || ((c >= `FMR_CH_UA) && (c <= `FMR_CH_UF)); // RULE3
    end
  endfunction

  function [3:0] fmr_hex_val;
    input [7:0] c;
    reg [7:0] t;
    begin
      if (c <= `FMR_CH_NINE)
        t = c - `FMR_CH_ZERO;
      else
        t = c - `FMR_CH_UA + {4'h0, `FMR_DIGIT_TEN};
      fmr_hex_val = t[3:0];
    end
  endfunction

  // nibble to uppercase hex character, used for both nibbles
  function [7:0] fmr_hex_char;
    input [3:0] n;
    begin
      if (n < `FMR_DIGIT_TEN)
        fmr_hex_char = `FMR_CH_ZERO + {4'h0, n}; // RULE3
      else
        fmr_hex_char = `FMR_CH_UA + {4'h0, n - `FMR_DIGIT_TEN}; // RULE3
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // receive side
  reg rx_on_r;
  reg [4:0] rx_cnt_r;
  reg nib_have_r;
  reg [3:0] nib_r;
  reg cr_seen_r;
  reg rx_bad_r;
  reg [`FMR_GAP_W-1:0] idle_cnt_r;
  reg [7:0] f_addr_r;
  reg [7:0] f_func_r;
  reg [15:0] f_p0_r;
  reg [15:0] f_p1_r;
  wire [7:0] rx_sum;
  wire [15:0] rx_crc;

  wire ch_hex = fmr_is_hex(rx_data);
  wire gap_ok = (idle_cnt_r >= GAP_CYCLES);
  wire a_start = ascii_mode & rx_valid & (rx_data == `FMR_CH_START); // RULE6
  wire a_in = ascii_mode & rx_valid & rx_on_r & ~a_start;
  wire a_push = a_in & ch_hex & nib_have_r & ~cr_seen_r; // RULE2
  wire a_end = a_in & (rx_data == `FMR_CH_LF) & cr_seen_r; // RULE7
  wire a_bad = a_in & ~a_end & (cr_seen_r | ~(ch_hex | (rx_data == `FMR_CH_CR)));
  wire r_start = ~ascii_mode & rx_valid & gap_ok; // RULE11
  wire r_push = ~ascii_mode & rx_valid & (gap_ok | rx_on_r); // RULE12
  wire r_end = ~ascii_mode & rx_on_r & gap_ok & ~rx_valid; // RULE11
  wire rx_start = a_start | r_start;
  wire push_raw = a_push | r_push;
  wire push_room = rx_start | (rx_cnt_r < `FMR_MAX_BYTES); // RULE9
  wire push = push_raw & push_room;
  wire [4:0] push_idx = rx_start ? 5'h00 : rx_cnt_r;
  wire [7:0] push_byte = ascii_mode ? {nib_r, fmr_hex_val(rx_data)} : rx_data; // RULE2
  wire frame_end = a_end | r_end;

  // silence timer, saturating once the gap is reached
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      idle_cnt_r <= {`FMR_GAP_W{1'b0}};
    else if (rx_valid)
      idle_cnt_r <= {`FMR_GAP_W{1'b0}};
    else if (!gap_ok)
      idle_cnt_r <= idle_cnt_r + 1'b1; // RULE11
  end

  // frame tracking, nibble pairing and header capture
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_on_r <= 1'b0;
      rx_cnt_r <= 5'h00;
      nib_have_r <= 1'b0;
      nib_r <= 4'h0;
      cr_seen_r <= 1'b0;
      rx_bad_r <= 1'b0;
      f_addr_r <= 8'h00;
      f_func_r <= 8'h00;
      f_p0_r <= 16'h0000;
      f_p1_r <= 16'h0000;
    end
    else
    begin
      if (rx_start)
      begin
        rx_on_r <= 1'b1; // RULE6
        rx_cnt_r <= 5'h00;
        nib_have_r <= 1'b0;
        cr_seen_r <= 1'b0;
        rx_bad_r <= 1'b0;
      end
      else if (frame_end)
        rx_on_r <= 1'b0;
      if (a_bad || (push_raw && !push_room))
        rx_bad_r <= 1'b1; // RULE9
      if (a_in && ch_hex && !nib_have_r)
      begin
        nib_r <= fmr_hex_val(rx_data); // RULE2
        nib_have_r <= 1'b1;
      end
      if (a_push)
        nib_have_r <= 1'b0;
      if (a_in && (rx_data == `FMR_CH_CR))
        cr_seen_r <= 1'b1; // RULE7
      if (push)
      begin
        rx_cnt_r <= push_idx + 5'h01;
        case (push_idx)
          5'h00: f_addr_r <= push_byte; // RULE8
          5'h01: f_func_r <= push_byte; // RULE8
          5'h02: f_p0_r[15:8] <= push_byte; // RULE16
          5'h03: f_p0_r[7:0] <= push_byte; // RULE16
          5'h04: f_p1_r[15:8] <= push_byte; // RULE18
          5'h05: f_p1_r[7:0] <= push_byte; // RULE18
          default: f_addr_r <= f_addr_r;
        endcase
      end
    end
  end

  // receive checksum; checking over the checksum bytes too must give zero
  fmr_chk u_rx_chk
  (
    .core_clk(core_clk),
    .rst(rst),
    .clr(rx_start),
    .en(push),
    .din(push_byte),
    .sum_r(rx_sum),
    .crc_r(rx_crc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // request acceptance
  reg [6:0] state_r;
  wire [4:0] need_len = `FMR_REQ_BODY + (ascii_mode ? `FMR_ASCII_CHK_LEN : `FMR_RTU_CHK_LEN);
  wire ok_len = (rx_cnt_r == need_len) & ~rx_bad_r & ~nib_have_r;
  wire ok_chk = ascii_mode ? (rx_sum == 8'h00) : (rx_crc == 16'h0000); // RULE19 RULE20 RULE22
  wire is_bcast = (f_addr_r == `FMR_ADDR_BCAST); // RULE14
  wire is_mine = (f_addr_r == station_address_setting) & (f_addr_r <= `FMR_ADDR_TOP) & ~is_bcast; // RULE1 RULE15
  wire is_rd = (f_func_r == `FMR_FUNC_READ) & (f_p1_r != 16'h0000) & (f_p1_r <= `FMR_MAX_WORDS); // RULE16 RULE9
  wire is_wr = (f_func_r == `FMR_FUNC_WRITE); // RULE18
  wire tx_idle = (state_r == S_IDLE);
  wire good = frame_end & ok_len & ok_chk & (is_rd | is_wr) & (is_mine | is_bcast); // RULE22
  wire do_wr = good & is_wr & (is_bcast | tx_idle);
  wire do_reply = good & is_mine & tx_idle; // RULE22

  // register write strobe and drop indication
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_wr_req_r <= 1'b0;
      reg_wr_addr_r <= 16'h0000;
      reg_wr_data_r <= 16'h0000;
      frame_drop_r <= 1'b0;
      char_bits_r <= `FMR_RTU_CHAR_BITS;
    end
    else
    begin
      reg_wr_req_r <= do_wr; // RULE18
      if (do_wr)
      begin
        reg_wr_addr_r <= f_p0_r;
        reg_wr_data_r <= f_p1_r;
      end
      frame_drop_r <= frame_end & ~do_wr & ~do_reply; // RULE22
      char_bits_r <= ascii_mode ? `FMR_ASCII_CHAR_BITS : `FMR_RTU_CHAR_BITS; // RULE4 RULE5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply build and send
  reg [4:0] len_r;
  reg [4:0] bidx_r;
  reg rd_wait_r;
  reg [7:0] rd_lo_r;
  reg [4:0] ptr_r;
  reg [7:0] byte_r;
  reg nib_sel_r;
  reg [1:0] tidx_r;
  reg mem_we;
  reg [7:0] mem_wd;
  reg emit;
  reg [7:0] emit_ch;
  reg emit_last;
  wire [7:0] mem_rd;
  wire [7:0] tx_sum;
  wire [15:0] tx_crc;
  wire [7:0] tx_lrc = 8'h00 - tx_sum; // RULE19
  wire reply_rd = (f_func_r == `FMR_FUNC_READ);
  wire hi_pos = reply_rd & (bidx_r >= `FMR_RD_HDR) & bidx_r[0];
  wire lo_pos = reply_rd & (bidx_r >= `FMR_RD_HDR) & ~bidx_r[0];
  wire [4:0] bm3 = bidx_r - `FMR_RD_HDR;
  wire can_load = ~tx_valid_r | tx_ready;
  wire build_last = (bidx_r == len_r - 5'h01);
  wire [1:0] tail_last = ascii_mode ? `FMR_ASCII_TAIL_LAST : `FMR_RTU_TAIL_LAST;

  // byte to write into the reply buffer during build
  always @*
  begin
    mem_we = 1'b0;
    mem_wd = 8'h00;
    if (state_r == S_BUILD)
    begin
      mem_we = ~hi_pos | rd_wait_r;
      if (hi_pos)
        mem_wd = reg_rd_data[15:8]; // RULE17
      else if (lo_pos)
        mem_wd = rd_lo_r; // RULE17
      else
      begin
        case (bidx_r)
          5'h00: mem_wd = f_addr_r; // RULE17 RULE21
          5'h01: mem_wd = f_func_r; // RULE17 RULE21
          5'h02: mem_wd = reply_rd ? {f_p1_r[6:0], 1'b0} : f_p0_r[15:8]; // RULE17 RULE21
          5'h03: mem_wd = f_p0_r[7:0]; // RULE21
          5'h04: mem_wd = f_p1_r[15:8]; // RULE21
          5'h05: mem_wd = f_p1_r[7:0]; // RULE21
          default: mem_wd = 8'h00;
        endcase
      end
    end
  end

  // character to hand to the line
  always @*
  begin
    emit = 1'b0;
    emit_ch = 8'h00;
    emit_last = 1'b0;
    case (state_r)
      S_START:
      begin
        emit = can_load;
        emit_ch = `FMR_CH_START; // RULE6
      end
      S_EMIT:
      begin
        emit = can_load;
        emit_ch = ascii_mode ? fmr_hex_char(nib_sel_r ? byte_r[3:0] : byte_r[7:4]) : byte_r; // RULE2 RULE12
        emit_last = ~ascii_mode | nib_sel_r;
      end
      S_TAIL:
      begin
        emit = can_load;
        emit_last = (tidx_r == tail_last);
        if (ascii_mode)
        begin
          case (tidx_r)
            2'h0: emit_ch = fmr_hex_char(tx_lrc[7:4]); // RULE10
            2'h1: emit_ch = fmr_hex_char(tx_lrc[3:0]); // RULE10
            2'h2: emit_ch = `FMR_CH_CR; // RULE7
            default: emit_ch = `FMR_CH_LF; // RULE7
          endcase
        end
        else
          emit_ch = tidx_r[0] ? tx_crc[15:8] : tx_crc[7:0]; // RULE13
      end
      default: emit = 1'b0;
    endcase
  end

  // reply sequencer
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= S_IDLE;
      len_r <= 5'h00;
      bidx_r <= 5'h00;
      rd_wait_r <= 1'b0;
      rd_lo_r <= 8'h00;
      ptr_r <= 5'h00;
      byte_r <= 8'h00;
      nib_sel_r <= 1'b0;
      tidx_r <= 2'h0;
      reg_rd_req_r <= 1'b0;
      reg_rd_addr_r <= 16'h0000;
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
    end
    else
    begin
      reg_rd_req_r <= 1'b0;
      if (emit)
      begin
        tx_valid_r <= 1'b1;
        tx_data_r <= emit_ch;
      end
      else if (tx_ready)
        tx_valid_r <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (do_reply)
          begin
            state_r <= S_BUILD;
            bidx_r <= 5'h00;
            rd_wait_r <= 1'b0;
            len_r <= reply_rd ? (`FMR_RD_HDR + {f_p1_r[3:0], 1'b0}) : `FMR_REQ_BODY; // RULE17 RULE21
          end
        end
        S_BUILD:
        begin
          if (hi_pos && !rd_wait_r)
          begin
            reg_rd_req_r <= 1'b1; // RULE17
            reg_rd_addr_r <= f_p0_r + {12'h000, bm3[4:1]};
            rd_wait_r <= 1'b1;
          end
          else
          begin
            if (hi_pos)
              rd_lo_r <= reg_rd_data[7:0];
            rd_wait_r <= 1'b0;
            bidx_r <= bidx_r + 5'h01;
            if (build_last)
            begin
              ptr_r <= 5'h00;
              state_r <= ascii_mode ? S_START : S_FETCH;
            end
          end
        end
        S_START:
        begin
          if (emit)
            state_r <= S_FETCH;
        end
        S_FETCH:
          state_r <= S_LOAD;
        S_LOAD:
        begin
          byte_r <= mem_rd;
          nib_sel_r <= 1'b0;
          state_r <= S_EMIT;
        end
        S_EMIT:
        begin
          if (emit)
          begin
            nib_sel_r <= 1'b1;
            if (emit_last)
            begin
              if (ptr_r == len_r - 5'h01)
              begin
                tidx_r <= 2'h0;
                state_r <= S_TAIL;
              end
              else
              begin
                ptr_r <= ptr_r + 5'h01;
                state_r <= S_FETCH;
              end
            end
          end
        end
        S_TAIL:
        begin
          if (emit)
          begin
            tidx_r <= tidx_r + 2'h1;
            if (emit_last)
              state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // reply buffer
  fmr_mem u_mem
  (
    .core_clk(core_clk),
    .wr_en(mem_we),
    .wr_addr(bidx_r),
    .wr_data(mem_wd),
    .rd_addr(ptr_r),
    .rd_data(mem_rd)
  );

  // transmit checksum over the reply bytes as they are loaded
  fmr_chk u_tx_chk
  (
    .core_clk(core_clk),
    .rst(rst),
    .clr(state_r == S_BUILD),
    .en(state_r == S_LOAD),
    .din(mem_rd),
    .sum_r(tx_sum),
    .crc_r(tx_crc)
  );

endmodule // fmr_framer
`default_nettype wire

// File: sim/fmr_framer_assertions.sv
// port-level assertions for the modbus slave framer
`timescale 1ns/1ps
`default_nettype none

module fmr_framer_chk
#(
  parameter logic [21:0] GAP_CYCLES = 22'h2625A0
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ascii_mode,
  input wire logic rx_valid,
  input wire logic tx_valid_r,
  input wire logic [7:0] tx_data_r,
  input wire logic tx_ready,
  input wire logic [3:0] char_bits_r,
  input wire logic reg_rd_req_r,
  input wire logic [15:0] reg_rd_addr_r,
  input wire logic reg_wr_req_r,
  input wire logic [15:0] reg_wr_addr_r,
  input wire logic [15:0] reg_wr_data_r,
  input wire logic frame_drop_r
);
  logic [21:0] idle_r;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // cycles since the last received byte, saturating
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      idle_r <= 22'h000000;
    else if (rx_valid)
      idle_r <= 22'h000000;
    else if (idle_r != 22'h3FFFFF)
      idle_r <= idle_r + 22'h000001;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // properties
  property p_bits;
    !$past(rst) |-> char_bits_r == ($past(ascii_mode) ? 4'hA : 4'hB);
  endproperty
  property p_hold;
    tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_data_r);
  endproperty
  property p_hex;
    tx_valid_r && ascii_mode |-> tx_data_r inside {8'h3A, 8'h0D, 8'h0A, [8'h30:8'h39], [8'h41:8'h46]};
  endproperty
  property p_rdpls;
    reg_rd_req_r |=> !reg_rd_req_r ##1 !reg_rd_req_r;
  endproperty
  property p_rdinc;
    reg_rd_req_r ##3 reg_rd_req_r |-> reg_rd_addr_r == $past(reg_rd_addr_r, 3) + 16'h0001;
  endproperty
  property p_rdaddr;
    !reg_rd_req_r |-> $stable(reg_rd_addr_r);
  endproperty
  property p_wrdat;
    !reg_wr_req_r |-> $stable(reg_wr_data_r) && $stable(reg_wr_addr_r);
  endproperty
  property p_quiet;
    reg_rd_req_r |-> !tx_valid_r;
  endproperty
  property p_act;
    frame_drop_r |-> !reg_wr_req_r && !reg_rd_req_r;
  endproperty
  property p_gap;
    !ascii_mode && (reg_wr_req_r || frame_drop_r) |-> idle_r + 22'h000002 >= GAP_CYCLES;
  endproperty

  a_bits: assert property (p_bits) else $error("char length wrong");
  a_hold: assert property (p_hold) else $error("tx char not held");
  a_hex: assert property (p_hex) else $error("bad ascii char sent");
  a_rdpls: assert property (p_rdpls) else $error("read pulses too close");
  a_rdinc: assert property (p_rdinc) else $error("read address not stepped");
  a_rdaddr: assert property (p_rdaddr) else $error("read address moved");
  a_wrdat: assert property (p_wrdat) else $error("write fields moved");
  a_quiet: assert property (p_quiet) else $error("send during build");
  a_act: assert property (p_act) else $error("dropped frame acted on");
  a_gap: assert property (p_gap) else $error("rtu end before gap");

  c_wr: cover property (reg_wr_req_r);
  c_rd2: cover property (reg_rd_req_r ##3 reg_rd_req_r);
  c_drop: cover property (frame_drop_r);
endmodule // fmr_framer_chk

bind fmr_framer fmr_framer_chk #(.GAP_CYCLES(GAP_CYCLES)) u_chk
(
  .core_clk(core_clk),
  .rst(rst),
  .ascii_mode(ascii_mode),
  .rx_valid(rx_valid),
  .tx_valid_r(tx_valid_r),
  .tx_data_r(tx_data_r),
  .tx_ready(tx_ready),
  .char_bits_r(char_bits_r),
  .reg_rd_req_r(reg_rd_req_r),
  .reg_rd_addr_r(reg_rd_addr_r),
  .reg_wr_req_r(reg_wr_req_r),
  .reg_wr_addr_r(reg_wr_addr_r),
  .reg_wr_data_r(reg_wr_data_r),
  .frame_drop_r(frame_drop_r)
);
`default_nettype wire

// File: sim/fmr_master.sv
// network master model: sends characters, collects the reply
`timescale 1ns/1ps
`default_nettype none

module fmr_master
(
  input wire logic core_clk,
  input wire logic tx_valid_r,
  input wire logic [7:0] tx_data_r,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready
);
  logic slow;
  logic [7:0] got[$];

  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
    slow = 1'b0;
  end

  // one whole serial character per strobe, 10 or 11 bits on the wire
  task automatic put_byte(input logic [7:0] b);
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask

  // line silence that bounds an rtu message
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // accept reply characters, stalling every other cycle when slow
  always @(posedge core_clk)
  begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid_r === 1'b1 && tx_ready)
      got.push_back(tx_data_r);
  end
endmodule // fmr_master
`default_nettype wire

// File: sim/tb_top.sv
// self-checking testbench for the modbus slave framer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  typedef logic [7:0] fmr_bq_t[$];
  localparam int GAP = 20;
  logic core_clk;
  logic rst;
  logic asc;
  logic [7:0] stn;
  logic rx_valid, tx_valid_r, tx_ready, reg_rd_req_r, reg_wr_req_r, frame_drop_r;
  logic [7:0] rx_data, tx_data_r;
  logic [3:0] char_bits_r;
  logic [15:0] reg_rd_addr_r, reg_rd_data, reg_wr_addr_r, reg_wr_data_r, wa, wd;
  int mismatches = 0;
  int checks_done = 0;
  int nwr, nrd, ndrop;

  always #2 core_clk = ~core_clk;

  fmr_framer #(.GAP_CYCLES(22'h000014)) dut
  (
    .core_clk(core_clk), .rst(rst), .ascii_mode(asc), .station_address_setting(stn),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid_r(tx_valid_r), .tx_data_r(tx_data_r),
    .tx_ready(tx_ready), .char_bits_r(char_bits_r), .reg_rd_req_r(reg_rd_req_r),
    .reg_rd_addr_r(reg_rd_addr_r), .reg_rd_data(reg_rd_data), .reg_wr_req_r(reg_wr_req_r),
    .reg_wr_addr_r(reg_wr_addr_r), .reg_wr_data_r(reg_wr_data_r), .frame_drop_r(frame_drop_r)
  );

  fmr_master mst
  (
    .core_clk(core_clk), .tx_valid_r(tx_valid_r), .tx_data_r(tx_data_r),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // register file stand-in: value derived from the register number
  function automatic logic [15:0] rv(input logic [15:0] a);
    return {a[7:0], ~a[7:0]};
  endfunction
  assign reg_rd_data = rv(reg_rd_addr_r);

  // count strobes seen at the register side
  always @(posedge core_clk)
  begin
    if (reg_wr_req_r === 1'b1)
    begin
      nwr++;
      wa = reg_wr_addr_r;
      wd = reg_wr_data_r;
    end
    if (reg_rd_req_r === 1'b1)
      nrd++;
    if (frame_drop_r === 1'b1)
      ndrop++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checksums and encoding
  function automatic logic [15:0] crc16(input fmr_bq_t m);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (m[i])
    begin
      c ^= {8'h00, m[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction

  function automatic logic [7:0] lrc8(input fmr_bq_t m);
    logic [7:0] s;
    s = 8'h00;
    foreach (m[i]) s += m[i];
    return -s;
  endfunction

  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction

  // wire image of a message; bad flips checksum bits
  function automatic fmr_bq_t enc(input fmr_bq_t m, input logic [7:0] bad);
    fmr_bq_t w, r;
    logic [15:0] c;
    c = crc16(m) ^ {8'h00, bad};
    w = m;
    if (asc)
    begin
      w.push_back(lrc8(m) ^ bad);
      r.push_back(8'h3A);
      foreach (w[i])
      begin
        r.push_back(hexc(w[i][7:4]));
        r.push_back(hexc(w[i][3:0]));
      end
      r.push_back(8'h0D);
      r.push_back(8'h0A);
    end
    else
    begin
      w.push_back(c[7:0]);
      w.push_back(c[15:8]);
      r = w;
    end
    return r;
  endfunction

  function automatic fmr_bq_t bq(input logic [47:0] v);
    fmr_bq_t r;
    for (int i = 5; i >= 0; i--) r.push_back(v[i*8+:8]);
    return r;
  endfunction

  function automatic fmr_bq_t rd_reply(input logic [15:0] s, input int n);
    fmr_bq_t r;
    logic [15:0] v;
    r = {stn, 8'h03, 8'(2 * n)};
    for (int i = 0; i < n; i++)
    begin
      v = rv(s + 16'(i));
      r.push_back(v[15:8]);
      r.push_back(v[7:0]);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic setup(input logic a, input logic s);
    @(posedge core_clk);
    asc <= a;
    mst.slow <= s;
    @(negedge core_clk);
    nwr = 0;
    nrd = 0;
    ndrop = 0;
  endtask

  task automatic send_msg(input fmr_bq_t m, input logic [7:0] bad);
    fmr_bq_t r;
    r = enc(m, bad);
    if (!asc) mst.idle(GAP);
    foreach (r[i]) mst.put_byte(r[i]);
    mst.idle(asc ? 3 : GAP + 3);
  endtask

  task automatic expect_reply(input fmr_bq_t m);
    fmr_bq_t r;
    int n;
    r = enc(m, 8'h00);
    n = 0;
    while (mst.got.size() < r.size() && n < 3000)
    begin
      @(posedge core_clk);
      n++;
    end
    mst.idle(6);
    chk(mst.got.size(), r.size());
    foreach (r[i]) if (i < mst.got.size()) chk(mst.got[i], r[i]);
    mst.got.delete();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_rtu_read;
    setup(1'b0, 1'b1);
    send_msg(bq(48'h1103_2102_0002), 8'h00);
    expect_reply(rd_reply(16'h2102, 2));
    chk(nrd, 2);
    chk(char_bits_r, 4'hB);
  endtask

  task t_asc_write;
    setup(1'b1, 1'b0);
    mst.put_byte(8'h3A);
    mst.put_byte(8'h30);
    send_msg(bq(48'h1106_0100_1770), 8'h00);
    expect_reply(bq(48'h1106_0100_1770));
    chk(nwr, 1);
    chk({wa, wd}, 32'h0100_1770);
    chk(char_bits_r, 4'hA);
  endtask

  task t_asc_read;
    setup(1'b1, 1'b1);
    send_msg(bq(48'h1103_00FA_0007), 8'h00);
    expect_reply(rd_reply(16'h00FA, 7));
    chk(nrd, 7);
  endtask

  task t_drops;
    logic [47:0] tab[4];
    logic [7:0] bad[4];
    tab = '{48'h1206_0001_0005, 48'h1106_0001_0005, 48'h1103_0000_0008, 48'h1103_0000_0000};
    bad = '{8'h00, 8'h01, 8'h00, 8'h00};
    setup(1'b0, 1'b0);
    foreach (tab[i])
    begin
      send_msg(bq(tab[i]), bad[i]);
      mst.idle(100);
      chk(ndrop, i + 1);
    end
    chk(nwr + nrd + mst.got.size(), 0);
    send_msg(bq(48'h0006_0002_BEEF), 8'h00);
    send_msg(bq(48'h0003_0000_0001), 8'h00);
    mst.idle(100);
    chk(nwr, 1);
    chk(nrd, 0);
    chk({wa, wd}, 32'h0002_BEEF);
    chk(mst.got.size(), 0);
    @(posedge core_clk);
    stn <= 8'hFE;
    send_msg(bq(48'hFE06_0003_1234), 8'h00);
    expect_reply(bq(48'hFE06_0003_1234));
    chk(nwr, 2);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // verdict, watchdog and main sequence
  task give_verdict;
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #100000;
    mismatches++;
    give_verdict();
  end

  initial
  begin
    core_clk = 1'b0;
    rst <= 1'b1;
    asc <= 1'b0;
    stn <= 8'h11;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_rtu_read();
    t_asc_write();
    t_asc_read();
    t_drops();
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
